// [core/frm_cfg.svh]
// constants for the reference monitor and rate control block
`ifndef FRM_CFG_SVH
`define FRM_CFG_SVH
// system clock rate and the rate at which bandwidth figures are nominal
`define FRM_CLK_HZ 32'h0098_9680
`define FRM_NOMINAL_HZ 32'h00B7_1B00
// reference absent after this many microseconds without an edge
`define FRM_TIMEOUT_US 32'h0000_1B58
`define FRM_TIMEOUT_CYC (`FRM_TIMEOUT_US * (`FRM_CLK_HZ / 32'h000F_4240))
// period deviation tolerated before the reference counts as unstable
`define FRM_TOL_CYC 32'h0000_0008
// stable periods needed to accept a rate, never above the detect limit
`define FRM_DETECT_PERIODS 32'h0000_0004
`define FRM_DETECT_LIMIT 32'h0000_0018
// bandwidth cap divisor 23.4 held in tenths
`define FRM_BW_CAP_TENTHS 32'h0000_00EA
// rate window half width in percent
`define FRM_RATE_TOL_PCT 32'h0000_0002
`endif

// [core/frm_pkg.sv]
// types for the reference monitor and rate control block
`default_nettype none
package frm_pkg;
  typedef enum logic [1:0] {
    MODE_SYNTH = 2'h0,
    MODE_MULT = 2'h1,
    MODE_SMART = 2'h2
  } pll_mode_t;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_TRACK = 4'h2,
    ST_HOLD = 4'h4,
    ST_UNLOCK = 4'h8
  } lock_state_t;
  typedef struct packed {
    logic absent;
    logic unstable;
    logic invalid;
  } err_flags_t;
  typedef struct packed {
    logic [15:0] frame_sync_out_div;
    logic [2:0] duty;
    logic [7:0] bclk_div;
  } frame_cfg_t;
endpackage : frm_pkg
`default_nettype wire

// [core/freq_ref_monitor.sv]
// reference monitor, holdover, loop bandwidth and automatic rate control
//
// Operation
// - absent flag latches while reference absent; write-one clear refused while absent
// - unstable flag latches on unstable or absent; clear refused meanwhile
// - smart mode freezes the loop ratio on a bad reference, output keeps running
// - holdover only after a valid reference moved the device into multiplier operation
// - plain multiplier mode stays unlocked while reference is lost, relocks on return
// - after holdover resync; same frequency keeps lock
// - bandwidth is base 1..128 Hz times 1 or 16, 1..2048 Hz
// - bandwidth capped at reference over 23.4, rounded down to a step
// - bandwidth scales with system clock; figures nominal at 12 MHz
// - rate control classifies the reference rate and derives the ratio
// - master frequency code picks 1x, 2x, 4x of family base; code 3 undefined
// - new rate detected within 24 stable reference periods
// - a rate jump marks the reference unstable, so lock drops and relocks at the new rate
// - frame sync follows the reference rate, duty from the duty field
// - bit clock from divider field: master clock division or frame multiple
// - unsupported bit clock division disables all clock outputs until valid
// - invalid configuration flag latches; clear refused while invalid
// - new frame and bit clock settings take effect at frame end
`timescale 1ns/1ps
`default_nettype none
`include "frm_cfg.svh"
module freq_ref_monitor #(
  parameter int TIMEOUT_CYC = `FRM_TIMEOUT_CYC,
  parameter int TOL_CYC = `FRM_TOL_CYC,
  parameter int DETECT_PERIODS = `FRM_DETECT_PERIODS,
  parameter int RW = 16
) (
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic REF_CLK_IN,
  input wire frm_pkg::pll_mode_t MODE_IN,
  input wire logic SYNTH_RATIO_NONZERO_IN,
  input wire logic [RW-1:0] RATIO_IN,
  input wire logic [2:0] LOOP_BANDWIDTH_BASE_IN,
  input wire logic LOOP_BANDWIDTH_MULTIPLIER_IN,
  input wire logic RATE_CONTROL_ENABLE_IN,
  input wire logic [1:0] RATE_CONTROL_MASTER_FREQ_IN,
  input wire logic RATE_CONTROL_BITCLK_MODE_IN,
  input wire logic [7:0] RATE_CONTROL_BITCLK_DIVIDER_IN,
  input wire logic [15:0] FRAME_SYNC_OUT_DIV_IN,
  input wire logic [7:0] BCLK_DIV_IN,
  input wire logic [2:0] FRAME_SYNC_DUTY_IN,
  input wire logic FRAME_END_IN,
  input wire frm_pkg::err_flags_t FLAG_CLEAR_IN,
  output frm_pkg::err_flags_t FLAGS_OUT,
  output logic [RW-1:0] LOOP_RATIO_OUT,
  output logic [3:0] BANDWIDTH_LOG2_OUT,
  output frm_pkg::frame_cfg_t FRAME_CFG_OUT,
  output logic CLK_OUTPUTS_EN_OUT,
  output logic LOCKED_OUT,
  output logic HOLDOVER_OUT,
  output logic [2:0] RATE_INDEX_OUT
);
  // ****************************************
  // reset and reference input conditioning
  // ****************************************
  logic [1:0] rst_sync;
  logic rst_n;
  logic r1, r2, r3, ref_lvl, next_ref_lvl, ref_rise;

  // reset released through two flops
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) rst_sync <= 2'h0;
    else rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  // three flops; level only moves once the last two agree, so is not read
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      r1 <= 1'b0;
      r2 <= 1'b0;
      r3 <= 1'b0;
      ref_lvl <= 1'b0;
    end else begin
      r1 <= REF_CLK_IN;
      r2 <= r1;
      r3 <= r2;
      ref_lvl <= next_ref_lvl;
    end
  end
  assign next_ref_lvl = (r2 == r3) ? r3 : ref_lvl;
  assign ref_rise = next_ref_lvl & ~ref_lvl;

  // ****************************************
  // period measurement, presence and stability
  // ****************************************
  logic [19:0] cnt, period;
  logic seen, have_period, unstable_lat, present, ref_ok;
  logic [4:0] stable_n;
  logic [19:0] diff;

  assign diff = (cnt + 20'h0_0001 > period) ? (cnt + 20'h0_0001 - period)
                                            : (period - cnt - 20'h0_0001);

  // time between rising edges; counter saturates at the absence timeout
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 20'h0_0000;
      period <= 20'h0_0000;
      seen <= 1'b0;
      have_period <= 1'b0;
      unstable_lat <= 1'b0;
      stable_n <= 5'h00;
    end else if (ref_rise) begin
      cnt <= 20'h0_0000;
      seen <= 1'b1;
      have_period <= seen & present;
      period <= cnt + 20'h0_0001;
      // a period far from the last one marks the reference unstable
      unstable_lat <= have_period & (diff > 20'(TOL_CYC));
      if (have_period && diff <= 20'(TOL_CYC) && stable_n != 5'h1F)
        stable_n <= stable_n + 5'h01;
      else if (!(have_period && diff <= 20'(TOL_CYC)))
        stable_n <= 5'h00;
    end else if (cnt < 20'(TIMEOUT_CYC)) begin
      cnt <= cnt + 20'h0_0001;
    end else begin
      // timeout: forget history so return needs fresh stable periods
      have_period <= 1'b0;
      stable_n <= 5'h00;
    end
  end
  assign present = seen & (cnt < 20'(TIMEOUT_CYC));

  // ****************************************
  // rate classification and ratio derivation
  // ****************************************
  logic rate_hit;
  logic [2:0] rate_idx;
  logic [RW-1:0] arc_ratio, new_ratio;
  logic [RW-1:0] fam_base;
  logic arc_on;

  function automatic logic [31:0] rate_hz(input logic [2:0] i);
    case (i)
      3'h0: rate_hz = 32'h0000_7D00;
      3'h1: rate_hz = 32'h0000_AC44;
      3'h2: rate_hz = 32'h0000_BB80;
      3'h3: rate_hz = 32'h0001_5888;
      3'h4: rate_hz = 32'h0001_7700;
      3'h5: rate_hz = 32'h0002_B110;
      default: rate_hz = 32'h0002_EE00;
    endcase
  endfunction

  // master clock cycles per reference period at code 00
  function automatic logic [RW-1:0] rate_ratio(input logic [2:0] i);
    case (i)
      3'h0: rate_ratio = RW'(16'h0180);
      3'h1, 3'h2: rate_ratio = RW'(16'h0100);
      3'h3, 3'h4: rate_ratio = RW'(16'h0080);
      default: rate_ratio = RW'(16'h0040);
    endcase
  endfunction

  // nearest supported rate within the percentage window
  always_comb begin
    logic [63:0] lhs;
    lhs = 64'h0;
    rate_hit = 1'b0;
    rate_idx = 3'h0;
    for (int i = 0; i < 7; i++) begin
      lhs = 64'(period) * 64'(rate_hz(3'(i))) * 64'h64;
      if (lhs >= 64'(`FRM_CLK_HZ) * 64'(32'h64 - `FRM_RATE_TOL_PCT) &&
          lhs <= 64'(`FRM_CLK_HZ) * 64'(32'h64 + `FRM_RATE_TOL_PCT)) begin
        rate_hit = 1'b1;
        rate_idx = 3'(i);
      end
    end
  end

  assign arc_on = RATE_CONTROL_ENABLE_IN;
  assign fam_base = rate_ratio(rate_idx);
  assign arc_ratio = fam_base << RATE_CONTROL_MASTER_FREQ_IN;
  assign new_ratio = arc_on ? arc_ratio : RATIO_IN;
  // good reference: present, stable long enough, and a known rate under rate control
  assign ref_ok = present & ~unstable_lat & (32'(stable_n) >= 32'(DETECT_PERIODS)) &
                  (~arc_on | rate_hit);

  // ****************************************
  // lock and holdover state machine
  // ****************************************
  frm_pkg::lock_state_t state, next_state;
  logic fam44, fam44_prev;
  logic smart;

  assign smart = (MODE_IN == frm_pkg::MODE_SMART);
  assign fam44 = rate_idx[0] & (rate_idx != 3'h6);

  // holdover is reachable only from tracking, never from start-up
  always_comb begin
    next_state = state;
    case (state)
      frm_pkg::ST_IDLE:
        if (ref_ok) next_state = frm_pkg::ST_TRACK;
      frm_pkg::ST_TRACK:
        if (!ref_ok)
          next_state = smart ? frm_pkg::ST_HOLD : frm_pkg::ST_UNLOCK;
        else if (arc_on && fam44 != fam44_prev)
          next_state = frm_pkg::ST_UNLOCK; // family jump cannot be held
      frm_pkg::ST_HOLD:
        if (ref_ok)
          // same ratio resumes seamlessly, otherwise relock
          next_state = (new_ratio == LOOP_RATIO_OUT) ? frm_pkg::ST_TRACK
                                                     : frm_pkg::ST_UNLOCK;
      frm_pkg::ST_UNLOCK:
        if (ref_ok) next_state = frm_pkg::ST_TRACK;
      default: next_state = frm_pkg::ST_IDLE;
    endcase
    if (MODE_IN == frm_pkg::MODE_SYNTH) next_state = frm_pkg::ST_IDLE;
  end

  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) state <= frm_pkg::ST_IDLE;
    else state <= next_state;
  end

  // family copied every cycle except while tracking a bad reference, so a family change seen while tracking forces relock
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) fam44_prev <= 1'b0;
    else if (state != frm_pkg::ST_TRACK || ref_ok) fam44_prev <= fam44;
  end

  // ratio follows the reference while tracking, frozen in holdover
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) LOOP_RATIO_OUT <= '0;
    else if (MODE_IN == frm_pkg::MODE_SYNTH) LOOP_RATIO_OUT <= RATIO_IN;
    else if (next_state == frm_pkg::ST_TRACK) LOOP_RATIO_OUT <= new_ratio;
  end

  // lock and running indicators; synth mode counts as locked
  logic run;
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      LOCKED_OUT <= 1'b0;
      HOLDOVER_OUT <= 1'b0;
      run <= 1'b0;
    end else begin
      LOCKED_OUT <= (MODE_IN == frm_pkg::MODE_SYNTH) |
                    (next_state == frm_pkg::ST_TRACK) | (next_state == frm_pkg::ST_HOLD);
      HOLDOVER_OUT <= (next_state == frm_pkg::ST_HOLD);
      run <= (MODE_IN == frm_pkg::MODE_SYNTH) | (next_state == frm_pkg::ST_TRACK) |
             (next_state == frm_pkg::ST_HOLD) |
             (smart & SYNTH_RATIO_NONZERO_IN & (next_state == frm_pkg::ST_IDLE));
    end
  end

  // ****************************************
  // loop bandwidth
  // ****************************************
  logic [3:0] bw_req, bw_cap;

  // steps are powers of two: base 2^code, modifier adds four octaves
  assign bw_req = {1'b0, LOOP_BANDWIDTH_BASE_IN} + {1'b0, LOOP_BANDWIDTH_MULTIPLIER_IN, 2'h0};

  // largest step k with 2^k * 23.4 <= fref; fref measured in system cycles
  always_comb begin
    logic [47:0] lhs;
    lhs = 48'h0;
    bw_cap = 4'hB;
    if (present && have_period) begin
      bw_cap = 4'h0;
      for (int k = 1; k < 12; k++) begin
        lhs = (48'(period) << k) * 48'(`FRM_BW_CAP_TENTHS);
        if (lhs <= 48'(`FRM_CLK_HZ) * 48'hA) bw_cap = 4'(k);
      end
    end
  end

  // code is nominal at 12 MHz; the loop's rate scales with this clock
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) BANDWIDTH_LOG2_OUT <= 4'h0;
    else BANDWIDTH_LOG2_OUT <= (bw_req > bw_cap) ? bw_cap : bw_req;
  end

  // ****************************************
  // frame sync and bit clock configuration
  // ****************************************
  frm_pkg::frame_cfg_t pend;
  logic [RW-1:0] bdiv_full;
  logic bdiv_exact, cfg_bad, applied;

  function automatic logic div_supported(input logic [RW-1:0] d);
    case (d)
      RW'(1), RW'(2), RW'(3), RW'(4), RW'(6), RW'(8), RW'(12), RW'(16),
      RW'(24), RW'(32), RW'(48), RW'(64): div_supported = 1'b1;
      default: div_supported = 1'b0;
    endcase
  endfunction

  // bit clock as master division, or master cycles per frame over bits per frame
  always_comb begin
    bdiv_full = RW'(RATE_CONTROL_BITCLK_DIVIDER_IN);
    bdiv_exact = (RATE_CONTROL_BITCLK_DIVIDER_IN != 8'h00);
    if (RATE_CONTROL_BITCLK_MODE_IN && bdiv_exact) begin
      bdiv_full = arc_ratio / RW'(RATE_CONTROL_BITCLK_DIVIDER_IN);
      bdiv_exact = (arc_ratio % RW'(RATE_CONTROL_BITCLK_DIVIDER_IN)) == '0;
    end
  end

  // unsupported division or undefined master code is an invalid setup
  assign cfg_bad = arc_on & ref_ok &
                   ((RATE_CONTROL_MASTER_FREQ_IN == 2'h3) | ~bdiv_exact |
                    ~div_supported(bdiv_full));

  // frame rate equals reference rate: one frame per reference period
  always_comb begin
    pend.duty = FRAME_SYNC_DUTY_IN;
    pend.frame_sync_out_div = arc_on ? 16'(arc_ratio) : FRAME_SYNC_OUT_DIV_IN;
    pend.bclk_div = arc_on ? 8'(bdiv_full) : BCLK_DIV_IN;
  end

  // settings swap at frame end, or at once on the first load after reset, so no frame is cut short
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      FRAME_CFG_OUT <= '0;
      applied <= 1'b0;
    end else if ((FRAME_END_IN || !applied) && !cfg_bad) begin
      FRAME_CFG_OUT <= pend;
      applied <= 1'b1;
    end
  end

  // clock outputs off while invalid; resume as soon as config is valid
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) CLK_OUTPUTS_EN_OUT <= 1'b0;
    else CLK_OUTPUTS_EN_OUT <= run & ~cfg_bad;
  end

  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) RATE_INDEX_OUT <= 3'h0;
    else if (ref_ok) RATE_INDEX_OUT <= rate_idx;
  end

  // ****************************************
  // latched error flags
  // ****************************************
  // set wins over clear, and clear is refused while the cause persists
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      FLAGS_OUT <= '0;
    end else begin
      if (!present) FLAGS_OUT.absent <= 1'b1;
      else if (FLAG_CLEAR_IN.absent) FLAGS_OUT.absent <= 1'b0;
      if (!present || unstable_lat) FLAGS_OUT.unstable <= 1'b1;
      else if (FLAG_CLEAR_IN.unstable) FLAGS_OUT.unstable <= 1'b0;
      if (cfg_bad) FLAGS_OUT.invalid <= 1'b1;
      else if (FLAG_CLEAR_IN.invalid) FLAGS_OUT.invalid <= 1'b0;
    end
  end

endmodule : freq_ref_monitor
`default_nettype wire

// [testbench/frm_ref_source.sv]
// partner model: the system that supplies the audio-rate reference clock
`timescale 1ns/1ps
`default_nettype none
module frm_ref_source (
  input wire logic clk_in,
  input wire logic run_in,
  input wire logic [15:0] period_in,
  output logic ref_out
);
  logic [15:0] count;
  // ************
  // period counter
  // ************
  // a new period applies at once, well inside five periods
  always_ff @(posedge clk_in) begin
    if (!run_in || count >= period_in - 16'h0001) begin
      count <= 16'h0000;
    end else begin
      count <= count + 16'h0001;
    end
  end
  // line stands low while stopped, as a real source would
  assign ref_out = run_in && (count < {1'b0, period_in[15:1]});
endmodule : frm_ref_source
`default_nettype wire

// [testbench/frm_checker.sv]
// port assertions for the reference monitor
`timescale 1ns/1ps
`default_nettype none
module frm_checker #(
  parameter int RW = 16
) (
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire frm_pkg::pll_mode_t MODE_IN,
  input wire logic [2:0] LOOP_BANDWIDTH_BASE_IN,
  input wire logic LOOP_BANDWIDTH_MULTIPLIER_IN,
  input wire logic RATE_CONTROL_ENABLE_IN,
  input wire logic [1:0] RATE_CONTROL_MASTER_FREQ_IN,
  input wire logic [2:0] FRAME_SYNC_DUTY_IN,
  input wire logic FRAME_END_IN,
  input wire frm_pkg::err_flags_t FLAG_CLEAR_IN,
  input wire frm_pkg::err_flags_t FLAGS_OUT,
  input wire logic [RW-1:0] LOOP_RATIO_OUT,
  input wire logic [3:0] BANDWIDTH_LOG2_OUT,
  input wire frm_pkg::frame_cfg_t FRAME_CFG_OUT,
  input wire logic CLK_OUTPUTS_EN_OUT,
  input wire logic LOCKED_OUT,
  input wire logic HOLDOVER_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  // ************
  // assertions
  // ************
  a_absent_hold: assert property (FLAGS_OUT.absent && !FLAG_CLEAR_IN.absent |=> FLAGS_OUT.absent)
    else $error("absent flag dropped without clear");
  a_unstable_hold: assert property (FLAGS_OUT.unstable && !FLAG_CLEAR_IN.unstable |=> FLAGS_OUT.unstable)
    else $error("unstable flag dropped without clear");
  a_invalid_hold: assert property (FLAGS_OUT.invalid && !FLAG_CLEAR_IN.invalid |=> FLAGS_OUT.invalid)
    else $error("invalid flag dropped without clear");
  a_bad_cfg_stops: assert property (MODE_IN == frm_pkg::MODE_MULT && LOCKED_OUT
    && RATE_CONTROL_ENABLE_IN && RATE_CONTROL_MASTER_FREQ_IN == 2'h3 |-> ##[1:2] !CLK_OUTPUTS_EN_OUT)
    else $error("clocks kept running on bad config");
  a_hold_frozen: assert property (HOLDOVER_OUT && $past(HOLDOVER_OUT) |-> $stable(LOOP_RATIO_OUT))
    else $error("ratio moved during holdover");
  a_mult_no_hold: assert property ((MODE_IN == frm_pkg::MODE_MULT) [*3] |-> !HOLDOVER_OUT)
    else $error("holdover in plain multiplier mode");
  a_mult_unlock: assert property (MODE_IN == frm_pkg::MODE_MULT && $rose(FLAGS_OUT.absent)
    |-> ##[0:2] !LOCKED_OUT)
    else $error("lock kept with reference gone");
  a_bw_limit: assert property (1'b1 |=> BANDWIDTH_LOG2_OUT <= {1'b0, $past(LOOP_BANDWIDTH_BASE_IN)}
    + {$past(LOOP_BANDWIDTH_MULTIPLIER_IN), 2'h0})
    else $error("bandwidth above request");
  a_cfg_at_end: assert property (!FRAME_END_IN && LOCKED_OUT |=> $stable(FRAME_CFG_OUT))
    else $error("frame settings changed mid frame");
  a_duty_taken: assert property (FRAME_END_IN && CLK_OUTPUTS_EN_OUT && !FLAGS_OUT.invalid
    |=> FRAME_CFG_OUT.duty == $past(FRAME_SYNC_DUTY_IN))
    else $error("duty not taken at frame end");
endmodule : frm_checker
bind freq_ref_monitor frm_checker #(.RW(RW)) i_frm_checker (
  .CLK_IN, .RST_N_IN, .MODE_IN, .LOOP_BANDWIDTH_BASE_IN, .LOOP_BANDWIDTH_MULTIPLIER_IN,
  .RATE_CONTROL_ENABLE_IN, .RATE_CONTROL_MASTER_FREQ_IN, .FRAME_SYNC_DUTY_IN, .FRAME_END_IN,
  .FLAG_CLEAR_IN, .FLAGS_OUT, .LOOP_RATIO_OUT, .BANDWIDTH_LOG2_OUT, .FRAME_CFG_OUT,
  .CLK_OUTPUTS_EN_OUT, .LOCKED_OUT, .HOLDOVER_OUT
);
`default_nettype wire

// [testbench/freq_ref_monitor_tb.sv]
// self-checking bench for the reference monitor
`timescale 1ns/1ps
`default_nettype none
module freq_ref_monitor_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic run = 1'b0;
  logic [15:0] per = 16'h00D0;
  logic ref_clk;
  frm_pkg::pll_mode_t mode = frm_pkg::MODE_MULT;
  logic rc = 1'b1;
  logic [2:0] bw = 3'h3; // narrow start, lowest step the reference domain tolerates
  logic bwm = 1'b0;
  logic [1:0] mf = 2'h0;
  logic bmode = 1'b0;
  logic [7:0] bdv = 8'h04;
  logic [2:0] duty = 3'h0;
  logic fend = 1'b0;
  frm_pkg::err_flags_t clr = 3'h0;
  frm_pkg::err_flags_t flags;
  frm_pkg::frame_cfg_t fcfg;
  logic [15:0] ratio;
  logic [3:0] bwo;
  logic [2:0] ridx;
  logic en;
  logic locked;
  logic hold;
  int bad_count = 0;
  int checks_done = 0;
  int cycles = 0;
  // 10 MHz system clock
  always #50 clk = ~clk;
  // synth ratio zero keeps rate control legal in smart mode
  freq_ref_monitor #(.TIMEOUT_CYC(800)) i_freq_ref_monitor (
    .CLK_IN(clk), .RST_N_IN(rst_n), .REF_CLK_IN(ref_clk), .MODE_IN(mode),
    .SYNTH_RATIO_NONZERO_IN(1'b0), .RATIO_IN(16'h0100), .LOOP_BANDWIDTH_BASE_IN(bw),
    .LOOP_BANDWIDTH_MULTIPLIER_IN(bwm), .RATE_CONTROL_ENABLE_IN(rc),
    .RATE_CONTROL_MASTER_FREQ_IN(mf), .RATE_CONTROL_BITCLK_MODE_IN(bmode),
    .RATE_CONTROL_BITCLK_DIVIDER_IN(bdv), .FRAME_SYNC_OUT_DIV_IN(16'h0100), .BCLK_DIV_IN(8'h04),
    .FRAME_SYNC_DUTY_IN(duty), .FRAME_END_IN(fend), .FLAG_CLEAR_IN(clr), .FLAGS_OUT(flags),
    .LOOP_RATIO_OUT(ratio), .BANDWIDTH_LOG2_OUT(bwo), .FRAME_CFG_OUT(fcfg),
    .CLK_OUTPUTS_EN_OUT(en), .LOCKED_OUT(locked), .HOLDOVER_OUT(hold), .RATE_INDEX_OUT(ridx)
  );
  frm_ref_source i_frm_ref_source (.clk_in(clk), .run_in(run), .period_in(per), .ref_out(ref_clk));
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt
  // callers step past the edge first, since seen is copied when the call starts
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  // wait n edges, then step past the last one so registered outputs read settled
  task automatic ws(input int n);
    wt(n);
    #1;
  endtask : ws
  // write-one clear strobe for one cycle
  task automatic clear(input frm_pkg::err_flags_t m);
    wt(1);
    clr <= m;
    wt(1);
    clr <= 3'h0;
    ws(1);
  endtask : clear
  task automatic frame_end();
    wt(1);
    fend <= 1'b1;
    wt(1);
    fend <= 1'b0;
    ws(1);
  endtask : frame_end
  // bounded wait for normal locked running
  task automatic wlock(input int n);
    for (int i = 0; i < n; i++) begin
      ws(1);
      if (locked === 1'b1 && hold === 1'b0) break;
    end
  endtask : wlock
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim
  // hang guard, well above the longest expected run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      bad_count++;
      end_sim();
    end
  end
  // ************
  // scenarios
  // ************
  initial begin
    wt(5);
    rst_n <= 1'b1;
    ws(4);
    check(flags, 3'h6);
    clear(3'h6);
    check(flags, 3'h6);
    check(locked, 1'b0);
    wt(1);
    run <= 1'b1;
    wlock(3000);
    check(locked, 1'b1);
    check(ridx, 3'h2);
    check(bwo, 4'h3);
    clear(3'h7);
    check(flags, 3'h0);
    // family of 48 kHz: 256 master cycles per period at code 0
    for (int k = 0; k < 3; k++) begin
      wt(1);
      mf <= k[1:0];
      ws(4);
      check(ratio, 16'h0100 << k);
    end
    wt(1);
    mf <= 2'h0;
    bw <= 3'h7; // 2048 Hz, above the 16 Hz floor for smart mode
    bwm <= 1'b1;
    ws(3);
    check(bwo, 4'hB);
    // double the rate without stopping, allow 24 periods
    wt(1);
    per <= 16'h0068;
    ws(24 * 104 + 10);
    check(ridx, 3'h4);
    check(locked, 1'b1);
    check(ratio, 16'h0080);
    check(flags.unstable, 1'b1);
    clear(3'h2);
    check(flags.unstable, 1'b0);
    // 32 kHz caps bandwidth at 2^10 Hz
    wt(1);
    per <= 16'h0138;
    ws(24 * 312 + 10);
    check(ridx, 3'h0);
    check(ratio, 16'h0180);
    check(bwo, 4'hA);
    // undefined master code, then an unsupported bit clock division
    for (int k = 0; k < 2; k++) begin
      wt(1);
      mf <= k ? 2'h0 : 2'h3;
      bdv <= k ? 8'h05 : 8'h04;
      ws(4);
      check(en, 1'b0);
      check(flags.invalid, 1'b1);
      clear(3'h1);
      check(flags.invalid, 1'b1);
      wt(1);
      mf <= 2'h0;
      bdv <= 8'h04;
      ws(4);
      check(en, 1'b1);
      clear(3'h1);
      check(flags.invalid, 1'b0);
    end
    wt(1);
    duty <= 3'h5;
    ws(4);
    check(fcfg.duty, 3'h0);
    frame_end();
    check(fcfg.duty, 3'h5);
    check(fcfg.frame_sync_out_div, 16'h0180);
    // divider as bits per frame: 384 master cycles over 64 bits is division 6
    wt(1);
    bmode <= 1'b1;
    bdv <= 8'h40;
    ws(4);
    check(en, 1'b1);
    frame_end();
    check(fcfg.bclk_div, 8'h06);
    // 384 over 5 bits is no whole division; settings held meanwhile
    wt(1);
    bdv <= 8'h05;
    ws(4);
    check(en, 1'b0);
    check(fcfg.bclk_div, 8'h06);
    wt(1);
    bmode <= 1'b0;
    bdv <= 8'h04;
    ws(4);
    check(en, 1'b1);
    clear(3'h1);
    check(flags.invalid, 1'b0);
    // plain multiplier loses lock while the reference is gone
    wt(1);
    run <= 1'b0;
    ws(1000);
    check(locked, 1'b0);
    check(hold, 1'b0);
    clear(3'h4);
    check(flags.absent, 1'b1);
    wt(1);
    run <= 1'b1;
    wlock(4000);
    check(locked, 1'b1);
    // smart mode holds the ratio and resyncs on return
    wt(1);
    mode <= frm_pkg::MODE_SMART;
    wt(1);
    run <= 1'b0;
    ws(1000);
    check(hold, 1'b1);
    check(locked, 1'b1);
    check(ratio, 16'h0180);
    wt(1);
    run <= 1'b1;
    wlock(4000);
    check(hold, 1'b0);
    check(locked, 1'b1);
    // fresh start in smart mode with no reference: no holdover
    wt(1);
    rst_n <= 1'b0;
    run <= 1'b0;
    wt(5);
    rst_n <= 1'b1;
    ws(1000);
    check(hold, 1'b0);
    check(locked, 1'b0);
    // synthesizer mode runs on the configured ratio, rate control off there
    wt(1);
    rc <= 1'b0;
    mode <= frm_pkg::MODE_SYNTH;
    ws(3);
    check(hold, 1'b0);
    check(ratio, 16'h0100);
    check(en, 1'b1);
    end_sim();
  end
endmodule : freq_ref_monitor_tb
`default_nettype wire
